// File: core/ips_pkg.sv
// Constants shared by the interrupt priority select block.
package ips_pkg;

    // ---------------------------------------------------------------
    // Register placement and layout
    // ---------------------------------------------------------------
    localparam logic [7:0] IPS_PRIO_ADDR = 8'hb8;
    localparam logic [7:0] IPS_PRIO_RESET = 8'h80;
    localparam logic [2:0] IPS_FIXED_TOP = 3'h4;
    localparam int IPS_NUM_SRC = 5;
    localparam int IPS_ID_W = 3;

    // ---------------------------------------------------------------
    // Field positions; bits 0 to 4 double as source numbers
    // ---------------------------------------------------------------
    localparam int IPS_EXT0_BIT = 0;
    localparam int IPS_TIMER0_BIT = 1;
    localparam int IPS_EXT1_BIT = 2;
    localparam int IPS_TIMER1_BIT = 3;
    localparam int IPS_SERIAL_BIT = 4;
    localparam int IPS_TOP_LSB = 5;

endpackage

// File: core/ips_level_arb.sv
// Fixed-order picker for the requests of one priority level.
`timescale 1ns/1ps
`default_nettype none
module ips_level_arb
    import ips_pkg::*;
(
    // Requests of this level, bit 0 polled first
    input wire logic [IPS_NUM_SRC-1:0] req_i,
    // Winner
    output logic any_o,
    output logic [IPS_ID_W-1:0] id_o
);

    // ---------------------------------------------------------------
    // Priority pick
    // ---------------------------------------------------------------

    // The loop runs downward so the lowest numbered request wins.
    always_comb begin
        any_o = 1'b0;
        id_o = '0;
        for (int i = IPS_NUM_SRC - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                any_o = 1'b1;
                id_o = IPS_ID_W'(i);
            end
        end
    end

endmodule
`default_nettype wire

// File: core/ips_top.sv
// Interrupt priority select register with two-level preemption control.
// How it works
// - Bits 7 to 5 always read as 100b and writes to them have no effect.
// - Bit 4 set puts the serial port interrupt at high priority, clear at low.
// - Bit 3 set puts the timer 1 interrupt at high priority, clear at low.
// - Bit 2 set puts external interrupt 1 at high priority, clear at low.
// - Bit 1 set puts the timer 0 interrupt at high priority, clear at low.
// - Bit 0 set puts external interrupt 0 at high priority, clear at low.
`timescale 1ns/1ps
`default_nettype none
module ips_top
    import ips_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Byte access to the special function register space
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_rd_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_rvalid_o,
    // Single-bit access to the bit-addressable space
    input wire logic [7:0] bit_addr_i,
    input wire logic bit_wr_i,
    input wire logic bit_wdata_i,
    input wire logic bit_rd_i,
    output logic bit_rdata_o,
    output logic bit_rvalid_o,
    // Pending and enabled requests, one per source
    input wire logic [IPS_NUM_SRC-1:0] irq_req_i,
    // Core handshake for entry and return of a service routine
    input wire logic irq_taken_i,
    input wire logic irq_return_i,
    // Request toward the core
    output logic irq_valid_o,
    output logic [IPS_ID_W-1:0] irq_id_o,
    output logic irq_high_o,
    // Current levels and service state
    output logic [IPS_NUM_SRC-1:0] prio_high_o,
    output logic in_service_low_o,
    output logic in_service_high_o
);

    // ---------------------------------------------------------------
    // Storage and decode
    // ---------------------------------------------------------------

    // Only the five priority bits are stored; the top three are constant.
    logic [IPS_NUM_SRC-1:0] prio_bits;
    logic serial_irq_high_priority;
    logic timer1_irq_high_priority;
    logic ext1_irq_high_priority;
    logic timer0_irq_high_priority;
    logic ext0_irq_high_priority;
    logic [7:0] prio_view;
    logic in_svc_low;
    logic in_svc_high;
    logic [IPS_NUM_SRC-1:0] req_high;
    logic [IPS_NUM_SRC-1:0] req_low;
    logic any_high;
    logic any_low;
    logic [IPS_ID_W-1:0] id_high;
    logic [IPS_ID_W-1:0] id_low;
    logic next_valid;
    logic [IPS_ID_W-1:0] next_id;
    logic next_high;
    logic req_valid;
    logic [IPS_ID_W-1:0] req_id;
    logic req_high_lvl;

    // True when a bit address falls inside this register.
    function automatic logic bit_hit(input logic [7:0] addr);
        bit_hit = (addr[7:3] == IPS_PRIO_ADDR[7:3]);
    endfunction

    // Named views of each field.
    assign serial_irq_high_priority = prio_bits[IPS_SERIAL_BIT];
    assign timer1_irq_high_priority = prio_bits[IPS_TIMER1_BIT];
    assign ext1_irq_high_priority = prio_bits[IPS_EXT1_BIT];
    assign timer0_irq_high_priority = prio_bits[IPS_TIMER0_BIT];
    assign ext0_irq_high_priority = prio_bits[IPS_EXT0_BIT];

    // The read view forces the unused top bits to their fixed pattern.
    assign prio_view = {IPS_FIXED_TOP, prio_bits};

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------

    // A byte write wins over a bit write in the same cycle, because the
    // byte carries the whole intended value. Bit writes above bit 4 land
    // on constant bits and are dropped.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prio_bits <= IPS_PRIO_RESET[IPS_NUM_SRC-1:0];
        end else if (sfr_wr_i && sfr_addr_i == IPS_PRIO_ADDR) begin
            prio_bits <= sfr_wdata_i[IPS_NUM_SRC-1:0];
        end else if (bit_wr_i && bit_hit(bit_addr_i)) begin
            if (int'(bit_addr_i[2:0]) < IPS_TOP_LSB) begin
                prio_bits[bit_addr_i[2:0]] <= bit_wdata_i;
            end
        end
    end

    // ---------------------------------------------------------------
    // Register reads
    // ---------------------------------------------------------------

    // Reads answer one cycle later; an unmapped byte address reads zero.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sfr_rdata_o <= 8'h00;
            sfr_rvalid_o <= 1'b0;
        end else begin
            sfr_rvalid_o <= sfr_rd_i;
            if (sfr_rd_i && sfr_addr_i == IPS_PRIO_ADDR) begin
                sfr_rdata_o <= prio_view;
            end else begin
                sfr_rdata_o <= 8'h00;
            end
        end
    end

    // Bit reads follow the same one-cycle timing.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_rdata_o <= 1'b0;
            bit_rvalid_o <= 1'b0;
        end else begin
            bit_rvalid_o <= bit_rd_i;
            if (bit_rd_i && bit_hit(bit_addr_i)) begin
                bit_rdata_o <= prio_view[bit_addr_i[2:0]];
            end else begin
                bit_rdata_o <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Level split
    // ---------------------------------------------------------------

    // Each source joins the high or the low group from its own bit.
    always_comb begin
        req_high = '0;
        req_low = '0;
        req_high[IPS_SERIAL_BIT] = irq_req_i[IPS_SERIAL_BIT]
            & serial_irq_high_priority;
        req_low[IPS_SERIAL_BIT] = irq_req_i[IPS_SERIAL_BIT]
            & ~serial_irq_high_priority;
        req_high[IPS_TIMER1_BIT] = irq_req_i[IPS_TIMER1_BIT]
            & timer1_irq_high_priority;
        req_low[IPS_TIMER1_BIT] = irq_req_i[IPS_TIMER1_BIT]
            & ~timer1_irq_high_priority;
        req_high[IPS_EXT1_BIT] = irq_req_i[IPS_EXT1_BIT]
            & ext1_irq_high_priority;
        req_low[IPS_EXT1_BIT] = irq_req_i[IPS_EXT1_BIT]
            & ~ext1_irq_high_priority;
        req_high[IPS_TIMER0_BIT] = irq_req_i[IPS_TIMER0_BIT]
            & timer0_irq_high_priority;
        req_low[IPS_TIMER0_BIT] = irq_req_i[IPS_TIMER0_BIT]
            & ~timer0_irq_high_priority;
        req_high[IPS_EXT0_BIT] = irq_req_i[IPS_EXT0_BIT]
            & ext0_irq_high_priority;
        req_low[IPS_EXT0_BIT] = irq_req_i[IPS_EXT0_BIT]
            & ~ext0_irq_high_priority;
    end

    // One picker per level keeps the polling order identical in both.
    ips_level_arb u_arb_high (
        .req_i(req_high),
        .any_o(any_high),
        .id_o(id_high)
    );

    ips_level_arb u_arb_low (
        .req_i(req_low),
        .any_o(any_low),
        .id_o(id_low)
    );

    // ---------------------------------------------------------------
    // Preemption decision
    // ---------------------------------------------------------------

    // High service blocks everything; low service admits only high.
    always_comb begin
        next_valid = 1'b0;
        next_id = '0;
        next_high = 1'b0;
        if (!in_svc_high) begin
            if (any_high) begin
                next_valid = 1'b1;
                next_id = id_high;
                next_high = 1'b1;
            end else if (any_low && !in_svc_low) begin
                next_valid = 1'b1;
                next_id = id_low;
            end
        end
    end

    // The request is held in flops; a take drops it for one cycle so the
    // same source is not offered again before the service state updates.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_valid <= 1'b0;
            req_id <= '0;
            req_high_lvl <= 1'b0;
        end else if (irq_taken_i) begin
            req_valid <= 1'b0;
        end else begin
            req_valid <= next_valid;
            req_id <= next_id;
            req_high_lvl <= next_high;
        end
    end

    // ---------------------------------------------------------------
    // Service state
    // ---------------------------------------------------------------

    // Entry marks the level that was offered. A return closes the highest
    // open level, since that routine is the one running. Entry and return
    // in one cycle count as entry, which the core cannot legally issue.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_svc_low <= 1'b0;
            in_svc_high <= 1'b0;
        end else if (irq_taken_i && req_valid) begin
            if (req_high_lvl) begin
                in_svc_high <= 1'b1;
            end else begin
                in_svc_low <= 1'b1;
            end
        end else if (irq_return_i) begin
            if (in_svc_high) begin
                in_svc_high <= 1'b0;
            end else begin
                in_svc_low <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------

    assign irq_valid_o = req_valid;
    assign irq_id_o = req_id;
    assign irq_high_o = req_high_lvl;
    assign prio_high_o = prio_bits;
    assign in_service_low_o = in_svc_low;
    assign in_service_high_o = in_svc_high;

endmodule
`default_nettype wire

// File: tb/ips_top_chk.sv
// Assertion checker for the interrupt priority select block.
`timescale 1ns/1ps
`default_nettype none
module ips_top_chk
    import ips_pkg::*;
(
    // Clock, reset and register access
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic [7:0] bit_addr_i,
    input wire logic bit_wr_i,
    input wire logic bit_wdata_i,
    input wire logic bit_rd_i,
    input wire logic bit_rdata_o,
    // Interrupt side
    input wire logic irq_valid_o,
    input wire logic [IPS_ID_W-1:0] irq_id_o,
    input wire logic irq_high_o,
    input wire logic [IPS_NUM_SRC-1:0] prio_high_o,
    input wire logic in_service_low_o,
    input wire logic in_service_high_o
);
    // -----------------------------------------------------------------
    // Helpers and properties
    // -----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic hit;
    logic bhit;
    logic [4:0] wd_low;
    logic [2:0] bidx;
    // Slices are named so that the past-value calls see plain signals.
    assign hit = sfr_addr_i == IPS_PRIO_ADDR;
    assign bhit = bit_addr_i[7:3] == IPS_PRIO_ADDR[7:3]
        && bit_addr_i[2:0] < 3'h5;
    assign wd_low = sfr_wdata_i[4:0];
    assign bidx = bit_addr_i[2:0];
    a_top_fixed: assert property (sfr_rd_i && hit |=>
        sfr_rdata_o[7:5] == IPS_FIXED_TOP) else $error("top bits wrong");
    a_bit_top: assert property (bit_rd_i && bit_addr_i == 8'hbf |=>
        bit_rdata_o) else $error("bit 7 not read as one");
    a_byte_write: assert property (sfr_wr_i && hit |=>
        prio_high_o == $past(wd_low)) else $error("byte write lost");
    a_read_back: assert property (sfr_rd_i && hit && !sfr_wr_i
        && !bit_wr_i |=> sfr_rdata_o[4:0] == $past(prio_high_o))
        else $error("read data differs");
    a_bit_write: assert property (bit_wr_i && !sfr_wr_i && bhit |=>
        prio_high_o[$past(bidx)] == $past(bit_wdata_i))
        else $error("bit write lost");
    a_offer_level: assert property (irq_valid_o && $stable(prio_high_o)
        |-> irq_high_o == prio_high_o[irq_id_o]) else $error("bad level");
    a_high_blocks: assert property (in_service_high_o |-> !irq_valid_o)
        else $error("offer during high service");
    a_low_high_only: assert property (in_service_low_o && irq_valid_o
        |-> irq_high_o) else $error("low offer in low service");
    cover property (sfr_wr_i && hit);
    cover property (in_service_low_o && irq_valid_o && irq_high_o);
    cover property (in_service_low_o && in_service_high_o);
endmodule
bind ips_top ips_top_chk u_chk (.sys_clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i,
    .sfr_wdata_i, .sfr_rd_i, .sfr_rdata_o, .bit_addr_i, .bit_wr_i,
    .bit_wdata_i, .bit_rd_i, .bit_rdata_o, .irq_valid_o, .irq_id_o,
    .irq_high_o, .prio_high_o, .in_service_low_o, .in_service_high_o);
`default_nettype wire

// File: tb/ips_top_tb_top.sv
// Self-checking bench for the interrupt priority select block.
`timescale 1ns/1ps
`default_nettype none
module ips_top_tb_top;
    import ips_pkg::*;
    logic sys_clk_i, rst_i, sfr_wr_i, sfr_rd_i, bit_wr_i, bit_wdata_i;
    logic bit_rd_i, irq_taken_i, irq_return_i, sfr_rvalid_o, bit_rdata_o;
    logic bit_rvalid_o, irq_valid_o, irq_high_o, isl, ish, bv;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, bit_addr_i, rd, wd;
    logic [4:0] irq_req_i, prio_high_o, m_prio;
    logic [2:0] irq_id_o;
    int error_cnt = 0, n_checks = 0, seed = 16, i;
    ips_top DUT (.sys_clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
        .sfr_rd_i, .sfr_rdata_o, .sfr_rvalid_o, .bit_addr_i, .bit_wr_i,
        .bit_wdata_i, .bit_rd_i, .bit_rdata_o, .bit_rvalid_o, .irq_req_i,
        .irq_taken_i, .irq_return_i, .irq_valid_o, .irq_id_o, .irq_high_o,
        .prio_high_o, .in_service_low_o(isl), .in_service_high_o(ish));
    // -----------------------------------------------------------------
    // Clock, watchdog and shared tasks
    // -----------------------------------------------------------------
    initial begin
        sys_clk_i = 0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    // Cuts a hang short; the whole run is far below this bound.
    initial begin
        #200us;
        error_cnt++;
        close_out();
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One byte or bit access; read data lands one cycle after the strobe.
    task automatic acc(input logic bw, input logic wr, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge sys_clk_i);
        sfr_addr_i <= a;
        bit_addr_i <= a;
        sfr_wdata_i <= d;
        bit_wdata_i <= d[0];
        {sfr_wr_i, sfr_rd_i} <= {wr & !bw, !wr & !bw};
        {bit_wr_i, bit_rd_i} <= {wr & bw, !wr & bw};
        @(posedge sys_clk_i);
        {sfr_wr_i, sfr_rd_i, bit_wr_i, bit_rd_i} <= 4'h0;
        #1;
        rd = bw ? {7'h0, bit_rdata_o} : sfr_rdata_o;
        if (!wr) chk({7'h0, bw ? bit_rvalid_o : sfr_rvalid_o}, 8'h01);
    endtask
    // Model: svc 0 idle, 1 low service, 2 high service.
    function automatic logic [4:0] pick(input logic [4:0] req, input int svc);
        for (int l = 1; l >= 0; l--)
            for (int s = 0; s < 5; s++)
                if (svc < 2 && req[s] && m_prio[s] == l[0] && l >= svc)
                    return {1'b1, l[0], 3'(s)};
        return 5'h00;
    endfunction
    // The offer is packed as valid, level and id, zero while nothing stands.
    task automatic offer(input logic [4:0] req, input int svc);
        logic [4:0] seen;
        @(posedge sys_clk_i);
        irq_req_i <= req;
        @(posedge sys_clk_i);
        #1;
        seen = irq_valid_o ? {1'b1, irq_high_o, irq_id_o} : 5'h00;
        chk({3'h0, seen}, {3'h0, pick(req, svc)});
    endtask
    task automatic pulse(input logic ret, input logic [1:0] exp_svc);
        @(posedge sys_clk_i);
        {irq_return_i, irq_taken_i} <= {ret, !ret};
        @(posedge sys_clk_i);
        {irq_return_i, irq_taken_i} <= 2'h0;
        #1;
        chk({6'h0, ish, isl}, {6'h0, exp_svc});
    endtask
    task automatic set_prio(input logic [7:0] d);
        acc(0, 1, IPS_PRIO_ADDR, d);
        m_prio = d[4:0];
        chk({3'h0, prio_high_o}, {3'h0, m_prio});
        acc(0, 0, IPS_PRIO_ADDR, 8'h00);
        chk(rd, {IPS_FIXED_TOP, m_prio});
    endtask
    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        {sfr_wr_i, sfr_rd_i, bit_wr_i, bit_rd_i, bit_wdata_i} = '0;
        {irq_taken_i, irq_return_i, sfr_addr_i, sfr_wdata_i} = '0;
        {bit_addr_i, irq_req_i, m_prio} = '0;
        rst_i = 1;
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 0;
        acc(0, 0, IPS_PRIO_ADDR, 8'h00);
        chk(rd, IPS_PRIO_RESET);
        acc(0, 0, 8'hb9, 8'h00);
        chk(rd, 8'h00);
        // Random levels; each source alone, then all, then a random mix.
        repeat (5) begin
            set_prio(8'($random(seed)));
            for (i = 0; i < 5; i++) offer(5'(1 << i), 0);
            offer(5'h1f, 0);
            offer(5'($random(seed)), 0);
        end
        // Bit writes; the top three bits must ignore them.
        for (i = 0; i < 8; i++) begin
            bv = ~i[0];
            acc(1, 1, IPS_PRIO_ADDR + 8'(i), {7'h0, bv});
            if (i < 5) m_prio[i] = bv;
            acc(1, 0, IPS_PRIO_ADDR + 8'(i), 8'h00);
            chk(rd, {7'h0, (i < 5) ? m_prio[i] : (i == 7)});
        end
        // Low service preempted by timer 1 at high, then unwound.
        // Only timer 1 is high; the set top bits must not stick.
        set_prio(8'he8);
        offer(5'h01, 0);
        pulse(0, 2'h1);
        offer(5'h09, 1);
        pulse(0, 2'h3);
        offer(5'h09, 2);
        pulse(1, 2'h1);
        offer(5'h01, 1);
        pulse(1, 2'h0);
        offer(5'h01, 0);
        // A second reset in mid-run restores the reset value.
        @(posedge sys_clk_i);
        rst_i <= 1;
        @(posedge sys_clk_i);
        rst_i <= 0;
        m_prio = 5'h00;
        acc(0, 0, IPS_PRIO_ADDR, 8'h00);
        chk(rd, IPS_PRIO_RESET);
        close_out();
    end
endmodule
`default_nettype wire
